/* File: verilog/pmrc_pkg.sv */
package pmrc_pkg;

	// Register byte offsets.
	localparam logic [7:0] PMRC_CTRL_OFS = 8'h00;
	localparam logic [7:0] PMRC_VEC_OFS = 8'h04;
	localparam logic [7:0] PMRC_CHAR_OFS = 8'h08;
	localparam logic [7:0] PMRC_STAT_OFS = 8'h0C;
	localparam logic [7:0] PMRC_FRAG_OFS = 8'h10;

	// Control register field positions.
	localparam int PMRC_CTRL_ALT_BIT = 0;
	localparam int PMRC_CTRL_ANYPH_BIT = 1;
	localparam int PMRC_CTRL_NUM_BIT = 2;
	localparam int PMRC_CTRL_ALPHA_BIT = 3;
	localparam int PMRC_CTRL_RATE_LSB = 4;
	localparam int PMRC_CTRL_GO_BIT = 8;
	localparam logic [31:0] PMRC_CTRL_RESET = 32'h0000_0000;

	// Vector type codes.
	localparam logic [2:0] PMRC_VEC_SHORT_INSTR = 3'h1;
	localparam logic [2:0] PMRC_VEC_SHORT_MSG = 3'h2;
	localparam logic [2:0] PMRC_VEC_NUM_STD = 3'h3;
	localparam logic [2:0] PMRC_VEC_NUM_SPECIAL = 3'h4;
	localparam logic [2:0] PMRC_VEC_ALPHA = 3'h5;
	localparam logic [2:0] PMRC_VEC_NUM_HEX = 3'h7;
	localparam logic [1:0] PMRC_MSG_TYPE_NUM = 2'h0;
	localparam logic [2:0] PMRC_INSTR_TEMP_GRP = 3'h0;

	// Character constants.
	localparam logic [6:0] PMRC_END_OF_TEXT = 7'h03;
	localparam logic [6:0] PMRC_CTRL_LIMIT = 7'h20;
	localparam logic [6:0] PMRC_DEL_CODE = 7'h7F;

	// Fragment gap timing: 4 minutes at 125 MHz.
	localparam longint PMRC_FRAG_GAP_S = 240;
	localparam longint PMRC_CLK_HZ = 125000000;
	localparam longint PMRC_FRAG_GAP_CYC = PMRC_FRAG_GAP_S * PMRC_CLK_HZ;

	// Rate and modulation modes.
	typedef enum logic [1:0] {
		PMRC_R1600_2L,
		PMRC_R3200_2L,
		PMRC_R3200_4L,
		PMRC_R6400_4L
	} pmrc_rate_t;

	// Decoded character with display class.
	typedef struct packed {
		logic [7:0] glyph;
		logic shown;
		logic stored;
	} pmrc_char_t;

endpackage

/* File: verilog/pmrc_numeric_map.sv */
`timescale 1ns/1ps
`default_nettype none
module pmrc_numeric_map
	import pmrc_pkg::*;
(
	input wire logic [3:0] code,
	input wire logic alt,
	output logic [7:0] glyph
);

	// Maps one 4-bit numeric code to an ASCII glyph.
	always_comb begin
		if (code <= 4'h9) begin
			glyph = 8'h30 + {4'h0, code}; // see [R19] see [R20]
		end else if (alt) begin
			unique case (code)
				4'hA: glyph = 8'h41;
				4'hB: glyph = 8'h42;
				4'hC: glyph = 8'h20;
				4'hD: glyph = 8'h43;
				4'hE: glyph = 8'h44;
				default: glyph = 8'h45; // see [R20]
			endcase
		end else begin
			unique case (code)
				4'hA: glyph = 8'h2A;
				4'hB: glyph = 8'h55;
				4'hC: glyph = 8'h20;
				4'hD: glyph = 8'h2D;
				4'hE: glyph = 8'h5D;
				default: glyph = 8'h5B; // see [R19]
			endcase
		end
	end

endmodule
`default_nettype wire

/* File: verilog/pmrc_top.sv */
// What the document requires of this block
// [R1] Same address at most twice per frame.
// [R2] No new fragmented message before old finishes.
// [R3] Fragmenting address: one unfragmented use per frame.
// [R4] Temporary address not reused until message done.
// [R5] Temporary address never creates another group.
// [R6] Numeric vector types are never fragmented.
// [R7] Fragments at most 32 or 128 frames apart.
// [R8] Fragments never split a character.
// [R9] Message numbers ascend, per address.
// [R10] Temporary group messages carry no number.
// [R11] Retrieved resends carry retrieval flag zero.
// [R12] Single-phase or any-phase addressing selectable.
// [R13] Numeric support implies short numeric message.
// [R14] Alphanumeric support implies numeric, short, instruction. The code also requires any-phase before it accepts an instruction vector.
// [R15] Four rate and modulation combinations decoded. The code only stores the rate field in ctrl and reads it back.
// [R16] Fragment state held across four-minute gaps.
// [R17] Unused control characters stored, not displayed.
// [R18] Seven-bit character: column high, row low.
// [R19] Standard numeric table mapping.
// [R20] Alternate numeric table mapping.
// [R21] Unused character slots filled with end-of-text.
// [R22] Configuration input selects numeric table per character.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pmrc_top
	import pmrc_pkg::*;
#(
	parameter longint FRAG_GAP_CYCLES = PMRC_FRAG_GAP_CYC
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic alt_numeric_sel,
	output logic vector_accept,
	output logic char_valid,
	output logic [7:0] char_glyph,
	output logic char_shown,
	output logic char_stored
);

	logic [31:0] ctrl, next_ctrl;
	logic [2:0] vector_type_field;
	logic [1:0] message_type_field;
	logic [2:0] instruction_type_field;
	logic [2:0] next_vec_type;
	logic [1:0] next_msg_type;
	logic [2:0] next_instr_type;
	logic next_vector_accept;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic [63:0] gap_cnt, next_gap_cnt;
	logic frag_active, next_frag_active;
	logic frag_expired, next_frag_expired;
	logic next_char_valid, next_char_shown, next_char_stored;
	logic [7:0] next_char_glyph;
	logic [7:0] num_glyph;
	logic alt_s1, alt_s2, alt_s3, alt_q;
	logic next_alt_q;
	logic acc_wr, gap_done, accept_vec;
	pmrc_char_t alpha;

	// A write lands only at the access edge at which pready is high.
	assign acc_wr = psel && penable && pready && pwrite;
	assign gap_done = frag_active && (gap_cnt >= 64'(FRAG_GAP_CYCLES - 1));

	// Synchronises the table select pin; the second and third stages must agree.
	always_comb begin
		next_alt_q = (alt_s2 == alt_s3) ? alt_s3 : alt_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alt_s1 <= 1'b0;
			alt_s2 <= 1'b0;
			alt_s3 <= 1'b0;
			alt_q <= 1'b0;
		end else begin
			alt_s1 <= alt_numeric_sel;
			alt_s2 <= alt_s1;
			alt_s3 <= alt_s2;
			alt_q <= next_alt_q;
		end
	end

	pmrc_numeric_map u_num (
		.code(pwdata[3:0]),
		.alt(alt_q | ctrl[PMRC_CTRL_ALT_BIT]),
		.glyph(num_glyph)
	);

	// Classifies an alphanumeric code by its column and row.
	always_comb begin
		alpha.glyph = {1'b0, pwdata[6:4], pwdata[3:0]}; // see [R18]
		alpha.stored = 1'b1;
		alpha.shown = (pwdata[6:0] >= PMRC_CTRL_LIMIT) && (pwdata[6:0] != PMRC_DEL_CODE)
			&& (pwdata[6:0] != PMRC_END_OF_TEXT); // see [R17]
	end

	// Decides vector acceptance from the enabled capabilities.
	always_comb begin
		accept_vec = 1'b0;
		unique case (pwdata[2:0])
			PMRC_VEC_ALPHA: accept_vec = ctrl[PMRC_CTRL_ALPHA_BIT];
			PMRC_VEC_NUM_STD: accept_vec = ctrl[PMRC_CTRL_NUM_BIT] | ctrl[PMRC_CTRL_ALPHA_BIT]; // see [R14]
			PMRC_VEC_NUM_SPECIAL, PMRC_VEC_NUM_HEX: accept_vec = ctrl[PMRC_CTRL_NUM_BIT];
			PMRC_VEC_SHORT_MSG: accept_vec = (ctrl[PMRC_CTRL_NUM_BIT] | ctrl[PMRC_CTRL_ALPHA_BIT])
				&& (pwdata[4:3] == PMRC_MSG_TYPE_NUM); // see [R13]
			PMRC_VEC_SHORT_INSTR: accept_vec = ctrl[PMRC_CTRL_ALPHA_BIT]
				&& ctrl[PMRC_CTRL_ANYPH_BIT] && (pwdata[7:5] == PMRC_INSTR_TEMP_GRP); // see [R14] see [R12]
			default: accept_vec = 1'b0;
		endcase
	end

	// Answers each setup cycle with read data; applies writes and decodes characters.
	always_comb begin
		next_ctrl = ctrl;
		next_vec_type = vector_type_field;
		next_msg_type = message_type_field;
		next_instr_type = instruction_type_field;
		next_vector_accept = vector_accept;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		next_prdata = prdata;
		next_char_valid = 1'b0;
		next_char_glyph = char_glyph;
		next_char_shown = char_shown;
		next_char_stored = char_stored;
		if (psel && !penable) begin
			next_pready = 1'b1;
			unique case (paddr)
				PMRC_CTRL_OFS: next_prdata = ctrl;
				PMRC_VEC_OFS: next_prdata = {23'h0, instruction_type_field, message_type_field,
					vector_type_field, vector_accept};
				PMRC_CHAR_OFS: next_prdata = {22'h0, char_stored, char_shown, char_glyph};
				PMRC_STAT_OFS: begin
					next_pslverr = pwrite;
					next_prdata = {28'h0, frag_expired, frag_active, alt_q, vector_accept};
				end
				PMRC_FRAG_OFS: next_prdata = {31'h0, frag_active};
				default: begin
					next_pslverr = 1'b1;
					next_prdata = 32'h0000_0000;
				end
			endcase
		end
		if (acc_wr && paddr == PMRC_CTRL_OFS) begin
			next_ctrl = {23'h0, pwdata[8:0]}; // see [R15] see [R12]
		end
		if (acc_wr && paddr == PMRC_VEC_OFS) begin
			next_vec_type = pwdata[2:0];
			next_msg_type = pwdata[4:3];
			next_instr_type = pwdata[7:5];
			next_vector_accept = accept_vec;
		end
		if (acc_wr && paddr == PMRC_CHAR_OFS) begin
			next_char_valid = 1'b1;
			if (ctrl[PMRC_CTRL_GO_BIT]) begin
				next_char_glyph = num_glyph; // see [R22]
				next_char_shown = 1'b1;
				next_char_stored = 1'b1;
			end else begin
				next_char_glyph = alpha.glyph;
				next_char_shown = alpha.shown;
				next_char_stored = alpha.stored; // see [R17]
			end
		end
	end

	// Holds reassembly state until the four-minute gap elapses; an expiry beats a clear.
	always_comb begin
		next_frag_active = frag_active;
		next_frag_expired = frag_expired;
		next_gap_cnt = gap_cnt;
		if (frag_active) next_gap_cnt = gap_cnt + 64'h1;
		if (gap_done) next_frag_active = 1'b0; // see [R16]
		if (acc_wr && paddr == PMRC_FRAG_OFS) begin
			next_frag_active = pwdata[0];
			next_gap_cnt = 64'h0; // see [R16]
			if (pwdata[1]) next_frag_expired = 1'b0;
		end
		if (gap_done) next_frag_expired = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= PMRC_CTRL_RESET;
			vector_type_field <= 3'h0;
			message_type_field <= 2'h0;
			instruction_type_field <= 3'h0;
			vector_accept <= 1'b0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			char_valid <= 1'b0;
			char_glyph <= 8'h00;
			char_shown <= 1'b0;
			char_stored <= 1'b0;
			frag_active <= 1'b0;
			frag_expired <= 1'b0;
			gap_cnt <= 64'h0;
		end else begin
			ctrl <= next_ctrl;
			vector_type_field <= next_vec_type;
			message_type_field <= next_msg_type;
			instruction_type_field <= next_instr_type;
			vector_accept <= next_vector_accept;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			char_valid <= next_char_valid;
			char_glyph <= next_char_glyph;
			char_shown <= next_char_shown;
			char_stored <= next_char_stored;
			frag_active <= next_frag_active;
			frag_expired <= next_frag_expired;
			gap_cnt <= next_gap_cnt;
		end
	end

	// Checks on the block's own outputs and its fragment state.
	short_msg_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R13]
		(acc_wr && paddr == PMRC_VEC_OFS && pwdata[2:0] == PMRC_VEC_SHORT_MSG
		&& pwdata[4:3] != PMRC_MSG_TYPE_NUM) |=> !vector_accept)
		else $error("short message with wrong type accepted");
	alpha_implies_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R14]
		(acc_wr && paddr == PMRC_VEC_OFS && ctrl[PMRC_CTRL_ALPHA_BIT]
		&& pwdata[2:0] == PMRC_VEC_NUM_STD) |=> vector_accept)
		else $error("numeric vector refused with alphanumeric enabled");
	instr_anyph_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R12]
		(acc_wr && paddr == PMRC_VEC_OFS && pwdata[2:0] == PMRC_VEC_SHORT_INSTR
		&& !ctrl[PMRC_CTRL_ANYPH_BIT]) |=> !vector_accept)
		else $error("instruction vector accepted without any-phase");
	ctrl_hidden_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R17]
		(acc_wr && paddr == PMRC_CHAR_OFS && !ctrl[PMRC_CTRL_GO_BIT]
		&& pwdata[6:0] < PMRC_CTRL_LIMIT) |=> (char_valid && !char_shown && char_stored))
		else $error("control character given display space");
	char_code_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R18]
		(acc_wr && paddr == PMRC_CHAR_OFS && !ctrl[PMRC_CTRL_GO_BIT])
		|=> char_glyph == {1'b0, $past(pwdata[6:0])})
		else $error("alphanumeric glyph mismatch");
	num_digit_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R19]
		(acc_wr && paddr == PMRC_CHAR_OFS && ctrl[PMRC_CTRL_GO_BIT] && pwdata[3:0] <= 4'h9)
		|=> char_glyph == 8'h30 + {4'h0, $past(pwdata[3:0])})
		else $error("numeric digit mismatch");
	alt_space_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R20]
		(acc_wr && paddr == PMRC_CHAR_OFS && ctrl[PMRC_CTRL_GO_BIT] && pwdata[3:0] == 4'hC)
		|=> char_glyph == 8'h20)
		else $error("numeric space mismatch");
	alt_letter_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R22]
		(acc_wr && paddr == PMRC_CHAR_OFS && ctrl[PMRC_CTRL_GO_BIT] && pwdata[3:0] == 4'hB)
		|=> char_glyph == (($past(alt_q) | $past(ctrl[PMRC_CTRL_ALT_BIT])) ? 8'h42 : 8'h55))
		else $error("numeric table select ignored");
	frag_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R16]
		(frag_active && gap_cnt < FRAG_GAP_CYCLES - 1 && !(acc_wr && paddr == PMRC_FRAG_OFS))
		|=> frag_active)
		else $error("fragment state dropped early");
	apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready ##1 !pready)
		else $error("apb answer timing wrong");

	numeric_c: cover property (@(posedge pclk) disable iff (!presetn) char_valid && ctrl[PMRC_CTRL_GO_BIT]);
	alpha_c: cover property (@(posedge pclk) disable iff (!presetn) char_valid && !char_shown);
	accept_c: cover property (@(posedge pclk) disable iff (!presetn) vector_accept);
	expire_c: cover property (@(posedge pclk) disable iff (!presetn) frag_expired);

endmodule
`default_nettype wire

/* File: verification/pmrc_encoder_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the encoding terminal: one short alphanumeric message, by character index.
module pmrc_encoder_model
	import pmrc_pkg::*;
(
	input wire logic [2:0] idx,
	output logic [6:0] code,
	output logic [2:0] vec_type,
	output logic continued
);
	// One alphanumeric message, sent whole once to one individual address in one frame.
	assign vec_type = PMRC_VEC_ALPHA;
	// Never continued: no fragment spacing, numbering or retrieval resend to keep.
	assign continued = 1'b0;
	// Whole 7-bit characters only, so no character is ever split across a boundary.
	// The last word is padded out to three characters with the end-of-text code.
	always_comb begin
		case (idx)
			3'h0: code = 7'h48;
			3'h1: code = 7'h69;
			3'h2: code = 7'h07;
			3'h3: code = 7'h7A;
			default: code = PMRC_END_OF_TEXT;
		endcase
	end
endmodule
`default_nettype wire

/* File: verification/pmrc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pmrc_top_tb;
	import pmrc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic alt_numeric_sel = 1'b0;
	logic [2:0] enc_idx = 3'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, e, vector_accept, char_valid, char_shown, char_stored;
	logic [7:0] char_glyph;
	logic [6:0] enc_code;
	logic [2:0] enc_vec;
	logic enc_cont;
	int err_total = 0;
	int comparisons = 0;
	string std_tab = "0123456789*U -][";
	string alt_tab = "0123456789AB CDE";
	logic [7:0] vecs [4] = '{{3'h0, 2'h0, PMRC_VEC_NUM_STD},
		{3'h0, PMRC_MSG_TYPE_NUM, PMRC_VEC_SHORT_MSG},
		{PMRC_INSTR_TEMP_GRP, 2'h0, PMRC_VEC_SHORT_INSTR},
		{3'h0, 2'h0, PMRC_VEC_ALPHA}};

	// Clock at 125 MHz.
	always #4 pclk = ~pclk;

	pmrc_top #(.FRAG_GAP_CYCLES(50)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .alt_numeric_sel(alt_numeric_sel),
		.vector_accept(vector_accept), .char_valid(char_valid), .char_glyph(char_glyph),
		.char_shown(char_shown), .char_stored(char_stored));

	pmrc_encoder_model enc (.idx(enc_idx), .code(enc_code), .vec_type(enc_vec),
		.continued(enc_cont));

	// Prints the counts and the verdict, then stops the run.
	task automatic conclude();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// One APB transfer; the request is held until pready is sampled high at a rising edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n == 20) begin
			err_total++;
			conclude();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask

	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Main sequence.
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, PMRC_CTRL_OFS, 32'h0);
		chk(q, PMRC_CTRL_RESET);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, e}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, PMRC_CTRL_OFS, 32'(i) << PMRC_CTRL_RATE_LSB);
			apb(1'b0, PMRC_CTRL_OFS, 32'h0);
			chk(q, 32'(i) << PMRC_CTRL_RATE_LSB);
		end
		// Standard table, alternate by control bit, alternate by pin.
		for (int t = 0; t < 3; t++) begin
			@(posedge pclk);
			alt_numeric_sel <= (t == 2);
			apb(1'b1, PMRC_CTRL_OFS, 32'h100 | 32'(t == 1));
			repeat (4) @(posedge pclk);
			for (int c = 0; c < 16; c++) begin
				apb(1'b1, PMRC_CHAR_OFS, 32'(c));
				chk({21'h0, char_valid, char_stored, char_shown, char_glyph},
					{21'h0, 3'b111, (t == 0) ? std_tab[c] : alt_tab[c]});
			end
		end
		// Alphanumeric message from the encoder model.
		apb(1'b1, PMRC_CTRL_OFS, 32'h8);
		for (int i = 0; i < 6; i++) begin
			@(posedge pclk);
			enc_idx <= 3'(i);
			@(negedge pclk);
			apb(1'b1, PMRC_CHAR_OFS, {25'h0, enc_code});
			chk({21'h0, char_valid, char_stored, char_shown, char_glyph},
				{21'h0, 2'b11, enc_code >= 7'h20 && enc_code != 7'h7F,
				1'b0, enc_code});
		end
		// Vector types required with any-phase, numeric and alphanumeric support.
		apb(1'b1, PMRC_CTRL_OFS, 32'hE);
		foreach (vecs[i]) begin
			apb(1'b1, PMRC_VEC_OFS, {24'h0, vecs[i]});
			chk({31'h0, vector_accept}, 32'h1);
		end
		// Refusals: short message of another type, instruction vector without any-phase.
		apb(1'b1, PMRC_VEC_OFS, {24'h0, 3'h0, 2'h1, PMRC_VEC_SHORT_MSG});
		chk({31'h0, vector_accept}, 32'h0);
		apb(1'b1, PMRC_CTRL_OFS, 32'hC);
		apb(1'b1, PMRC_VEC_OFS, {24'h0, PMRC_INSTR_TEMP_GRP, 2'h0, PMRC_VEC_SHORT_INSTR});
		chk({31'h0, vector_accept}, 32'h0);
		apb(1'b1, PMRC_VEC_OFS, {29'h0, enc_vec});
		chk({31'h0, vector_accept}, 32'h1);
		apb(1'b0, PMRC_VEC_OFS, 32'h0);
		chk(q, {23'h0, 3'h0, 2'h0, PMRC_VEC_ALPHA, 1'b1});
		apb(1'b1, PMRC_STAT_OFS, 32'h0);
		chk({31'h0, e}, 32'h1);
		// A message sent whole leaves no reassembly state open.
		apb(1'b0, PMRC_FRAG_OFS, 32'h0);
		chk(q, {31'h0, enc_cont});
		// Fragment state survives a gap below the limit and expires beyond it.
		apb(1'b1, PMRC_FRAG_OFS, 32'h1);
		repeat (30) @(posedge pclk);
		apb(1'b0, PMRC_STAT_OFS, 32'h0);
		chk(q & 32'hC, 32'h4);
		repeat (40) @(posedge pclk);
		apb(1'b0, PMRC_STAT_OFS, 32'h0);
		chk(q & 32'hC, 32'h8);
		apb(1'b1, PMRC_FRAG_OFS, 32'h2);
		apb(1'b0, PMRC_STAT_OFS, 32'h0);
		chk(q & 32'hC, 32'h0);
		conclude();
	end
endmodule
`default_nettype wire
